// File: logic/msbc_device.sv
// monitor end: straps, register map, status and broadcast transmitter
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
// Behaviour
// - high/low straps select broadcast, bus disabled
// - one 18-bit frame per conversion, 15.3kHz; a conversion done while a frame is still going out sends none
// - each bit: value phase, then complement
// - line high in conversion, falls at end
// - start, dummy, then two channel bits
// - ten result bits msb first, three faults
// - parity last, then line idles high
// - receiver deglitches start edge after 10us
// - receiver measures half bit from edges
// - receiver samples 3/4 bit after edges
// - receiver aborts frames beyond 2.4ms
// - each strap pin read as three states
// - strap pairs map addresses, plus two specials
// - only low command nibble is decoded
// - results split msbs even, lsbs odd
// - result writes only when unlock bit set
// - status shows switch on, gp input level
// - status shows short switch, board detect
// - status shows power bad, overcurrent now (bit 3 latches supplyGood uninverted at pgCheckEnd)
// - status shows undervoltage and high line
// - frame fault bits are latched log flags
module msbc_device (
	// clock and reset
	input  wire logic               ref_clk,
	input  wire logic               rst_b,
	// broadcast link
	msbc_link_if.dev                link,
	// address straps
	input  wire msbc_pkg::msbc_pin_t addrSelectHi,
	input  wire msbc_pkg::msbc_pin_t addrSelectLo,
	input  wire logic [7:0]         addrProbe,
	// register port
	input  wire logic [7:0]         regAddr,
	input  wire logic [7:0]         regWrData,
	input  wire logic               regWr,
	input  wire logic               regRd,
	output logic [7:0]              regRdData,
	// converter
	input  wire logic               convBusy,
	input  wire logic               convDone,
	input  wire logic [9:0]         convResult,
	// monitored conditions
	input  wire logic               switchOn,
	input  wire logic               pgioLevel,
	input  wire logic               senseShort,
	input  wire logic               boardDetect,
	input  wire logic               supplyGood,
	input  wire logic               pgCheckEnd,
	input  wire logic               overcurrentNow,
	input  wire logic               undervoltUpper,
	input  wire logic               undervoltLower,
	input  wire logic               highLineComparator,
	input  wire logic               ocEvent,
	input  wire logic               uvEvent,
	input  wire logic               ovEvent,
	// configuration out
	output logic                    broadcastMode,
	output logic                    busEnable,
	output logic [7:0]              busAddr,
	output logic                    addrHit,
	output logic [7:0]              alertEnables,
	output logic [7:0]              control
);
	// strap decode: {broadcast, address index}
	function automatic logic [3:0] strapDecode(
		input msbc_pkg::msbc_pin_t hi,
		input msbc_pkg::msbc_pin_t lo
	);
		case ({hi, lo})
			{msbc_pkg::PIN_LOW, msbc_pkg::PIN_LOW}:   strapDecode = 4'h0;
			{msbc_pkg::PIN_LOW, msbc_pkg::PIN_OPEN}:  strapDecode = 4'h1;
			{msbc_pkg::PIN_HIGH, msbc_pkg::PIN_OPEN}: strapDecode = 4'h2;
			{msbc_pkg::PIN_LOW, msbc_pkg::PIN_HIGH}:  strapDecode = 4'h3;
			{msbc_pkg::PIN_OPEN, msbc_pkg::PIN_LOW}:  strapDecode = 4'h4;
			{msbc_pkg::PIN_OPEN, msbc_pkg::PIN_OPEN}: strapDecode = 4'h5;
			{msbc_pkg::PIN_HIGH, msbc_pkg::PIN_HIGH}: strapDecode = 4'h6;
			{msbc_pkg::PIN_OPEN, msbc_pkg::PIN_HIGH}: strapDecode = 4'h7;
			{msbc_pkg::PIN_HIGH, msbc_pkg::PIN_LOW}:  strapDecode = 4'h8;
			default:                                  strapDecode = 4'h0;
		endcase
	endfunction

	logic [7:0]         status_r;
	logic [7:0]         fault_r;
	logic [7:0]         fault_nxt;
	logic [7:0]         alert_r;
	logic [7:0]         control_r;
	logic [7:0]         adcHi_r [3];
	logic [1:0]         adcLo_r [3];
	logic [7:0]         rdData_r;
	logic               powerBad_r;
	logic               broadcast_r;
	logic               busEnable_r;
	logic [7:0]         busAddr_r;
	logic               addrHit_r;
	logic [1:0]         chan_r;
	msbc_pkg::msbc_tx_t txState_r;
	logic [9:0]         div_r;
	logic [4:0]         bitCnt_r;
	logic [17:0]        shift_r;
	logic               line_r;

	// decode
	wire [3:0]  strap = strapDecode(addrSelectHi, addrSelectLo);
	wire        strapBroadcast = strap[3];
	wire [7:0]  strapAddr = msbc_pkg::ADDR_BASE | {3'h0, strap[2:0], 1'b0};
	wire        probeHit = !broadcast_r && (addrProbe[7:1] == busAddr_r[7:1]
		|| addrProbe == msbc_pkg::ADDR_MASS
		|| addrProbe == msbc_pkg::ADDR_ALERT);
	wire [3:0]  ptr = regAddr[3:0];
	wire        isAdc = ptr >= msbc_pkg::REG_ADC_FIRST
		&& ptr <= msbc_pkg::REG_ADC_LAST;
	wire [3:0]  adcOff = ptr - msbc_pkg::REG_ADC_FIRST;
	wire [1:0]  adcIdx = adcOff[2:1];
	wire        adcOdd = adcOff[0];
	wire        unlock = control_r[msbc_pkg::CTRL_UNLOCK];
	wire        adcWr = regWr && isAdc && unlock && !(convDone && adcIdx == chan_r);
	wire        gpIn = {control_r[msbc_pkg::CTRL_POWER_GOOD_GP_PIN_HI],
		control_r[msbc_pkg::CTRL_POWER_GOOD_GP_PIN_LO]} == msbc_pkg::POWER_GOOD_GP_PIN_GP_IN;
	wire [7:0]  statusNow = {switchOn, pgioLevel && gpIn, senseShort && !switchOn,
		boardDetect, powerBad_r, overcurrentNow,
		!undervoltUpper && !undervoltLower, highLineComparator};
	wire [2:0]  faultEv = {ocEvent, uvEvent, ovEvent};
	wire [7:0]  adcRead = adcOdd ? {6'h00, adcLo_r[adcIdx]} : adcHi_r[adcIdx];
	wire [7:0]  rdMux = ptr == msbc_pkg::REG_STATUS ? status_r :
		ptr == msbc_pkg::REG_FAULT ? fault_r :
		ptr == msbc_pkg::REG_ALERT ? alert_r :
		ptr == msbc_pkg::REG_CONTROL ? control_r :
		isAdc ? adcRead : 8'h00;
	wire [2:0]  frameFault = {fault_r[msbc_pkg::FLT_OC], fault_r[msbc_pkg::FLT_UV],
		fault_r[msbc_pkg::FLT_OV]};
	wire [14:0] payload = {chan_r, convResult, frameFault};
	wire [17:0] frame = {1'b0, 1'b0, payload, ^payload};
	wire        txStart = convDone && broadcast_r && txState_r == msbc_pkg::TX_IDLE;
	wire        tick = div_r == msbc_pkg::HALF_BIT_CYC - 10'h001;
	wire [1:0]  chanNext = chan_r == msbc_pkg::CHAN_LAST ? 2'h0 : chan_r + 2'h1;

	// set wins over a software write to the log
	always_comb
	begin
		fault_nxt = regWr && ptr == msbc_pkg::REG_FAULT ? regWrData : fault_r;
		fault_nxt[msbc_pkg::FLT_OC] = fault_nxt[msbc_pkg::FLT_OC] | faultEv[2];
		fault_nxt[msbc_pkg::FLT_UV] = fault_nxt[msbc_pkg::FLT_UV] | faultEv[1];
		fault_nxt[msbc_pkg::FLT_OV] = fault_nxt[msbc_pkg::FLT_OV] | faultEv[0];
	end

	// straps are followed continuously; they are meant to be tied
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			broadcast_r <= 1'b0;
			busEnable_r <= 1'b1;
			busAddr_r <= msbc_pkg::ADDR_BASE;
			addrHit_r <= 1'b0;
			status_r <= 8'h00;
			powerBad_r <= 1'b0;
		end
		else
		begin
			broadcast_r <= strapBroadcast;
			busEnable_r <= !strapBroadcast;
			busAddr_r <= strapAddr;
			addrHit_r <= probeHit;
			status_r <= statusNow;
			if (pgCheckEnd)
				powerBad_r <= supplyGood;
		end
	end

	// register file
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			fault_r <= msbc_pkg::FAULT_RST;
			alert_r <= msbc_pkg::ALERT_RST;
			control_r <= msbc_pkg::CONTROL_RST;
			rdData_r <= 8'h00;
			chan_r <= 2'h0;
			for (int i = 0; i < 3; i++)
			begin
				adcHi_r[i] <= 8'h00;
				adcLo_r[i] <= 2'h0;
			end
		end
		else
		begin
			fault_r <= fault_nxt;
			rdData_r <= regRd ? rdMux : 8'h00;
			if (regWr && ptr == msbc_pkg::REG_ALERT)
				alert_r <= regWrData;
			if (regWr && ptr == msbc_pkg::REG_CONTROL)
				control_r <= regWrData;
			if (adcWr && adcOdd)
				adcLo_r[adcIdx] <= regWrData[1:0];
			if (adcWr && !adcOdd)
				adcHi_r[adcIdx] <= regWrData;
			if (convDone)
			begin
				adcHi_r[chan_r] <= convResult[9:2];
				adcLo_r[chan_r] <= convResult[1:0];
				chan_r <= chanNext;
			end
		end
	end

	// transmitter: one half-bit per divider tick
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			txState_r <= msbc_pkg::TX_IDLE;
			line_r <= 1'b1;
			div_r <= 10'h000;
			bitCnt_r <= 5'h00;
			shift_r <= 18'h00000;
		end
		else
		begin
			div_r <= tick || txState_r == msbc_pkg::TX_IDLE ? 10'h000 : div_r + 10'h001;
			case (txState_r)
				msbc_pkg::TX_IDLE:
				begin
					line_r <= !txStart;
					if (txStart)
					begin
						shift_r <= frame;
						bitCnt_r <= 5'h00;
						txState_r <= msbc_pkg::TX_FIRST;
					end
				end
				msbc_pkg::TX_FIRST:
					if (tick)
					begin
						line_r <= !shift_r[17];
						txState_r <= msbc_pkg::TX_SECOND;
					end
				msbc_pkg::TX_SECOND:
					if (tick && bitCnt_r == msbc_pkg::FRAME_LAST)
					begin
						line_r <= 1'b1;
						txState_r <= msbc_pkg::TX_IDLE;
					end
					else if (tick)
					begin
						line_r <= shift_r[16];
						shift_r <= {shift_r[16:0], 1'b0};
						bitCnt_r <= bitCnt_r + 5'h01;
						txState_r <= msbc_pkg::TX_FIRST;
					end
				default:
					txState_r <= msbc_pkg::TX_IDLE;
			endcase
		end
	end

	// outputs
	assign link.serialDataOut = line_r;
	assign regRdData = rdData_r;
	assign broadcastMode = broadcast_r;
	assign busEnable = busEnable_r;
	assign busAddr = busAddr_r;
	assign addrHit = addrHit_r;
	assign alertEnables = alert_r;
	assign control = control_r;
endmodule

// File: logic/msbc_pkg.sv
// shared constants and types for the broadcast monitor link
package msbc_pkg;
	// timing
	localparam int CLK_HZ = 20000000;
	localparam int CLK_NS = 50;
	localparam int BIT_RATE_HZ = 15300;
	localparam int HALF_BIT_INT = CLK_HZ / (2 * BIT_RATE_HZ);
	localparam logic [9:0] HALF_BIT_CYC = 10'(HALF_BIT_INT);
	localparam int GLITCH_NS = 10000;
	localparam logic [15:0] GLITCH_CYC = 16'((GLITCH_NS + CLK_NS - 1) / CLK_NS);
	localparam int FRAME_US = 1200;
	localparam int TIMEOUT_CYC = (2 * FRAME_US * 1000) / CLK_NS;
	// frame layout
	localparam logic [4:0] FRAME_LAST = 5'h11;
	localparam logic [3:0] RX_LAST = 4'hf;
	// register offsets
	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam logic [3:0] REG_FAULT = 4'h1;
	localparam logic [3:0] REG_ALERT = 4'h2;
	localparam logic [3:0] REG_CONTROL = 4'h3;
	localparam logic [3:0] REG_ADC_FIRST = 4'h4;
	localparam logic [3:0] REG_ADC_LAST = 4'h9;
	// reset values
	localparam logic [7:0] FAULT_RST = 8'h00;
	localparam logic [7:0] ALERT_RST = 8'h00;
	localparam logic [7:0] CONTROL_RST = 8'h00;
	// field positions
	localparam int CTRL_UNLOCK = 5;
	localparam int CTRL_POWER_GOOD_GP_PIN_HI = 7;
	localparam int CTRL_POWER_GOOD_GP_PIN_LO = 6;
	localparam logic [1:0] POWER_GOOD_GP_PIN_GP_IN = 2'h3;
	localparam int FLT_OC = 2;
	localparam int FLT_UV = 1;
	localparam int FLT_OV = 0;
	// bus addresses (write form, r/w bit clear, except ADDR_ALERT 8'h19 with it set)
	localparam logic [7:0] ADDR_BASE = 8'h20;
	localparam logic [7:0] ADDR_MASS = 8'h3e;
	localparam logic [7:0] ADDR_ALERT = 8'h19;
	localparam logic [1:0] CHAN_LAST = 2'h2;
	// three-state strap pin
	typedef enum logic [1:0] {
		PIN_LOW  = 2'b00,
		PIN_HIGH = 2'b01,
		PIN_OPEN = 2'b10
	} msbc_pin_t;
	typedef enum logic [1:0] {
		TX_IDLE   = 2'b00,
		TX_FIRST  = 2'b01,
		TX_SECOND = 2'b10
	} msbc_tx_t;
	typedef enum logic [2:0] {
		RX_IDLE   = 3'b000,
		RX_GLITCH = 3'b001,
		RX_START  = 3'b010,
		RX_HALF   = 3'b011,
		RX_RISE   = 3'b100,
		RX_DELAY  = 3'b101,
		RX_EDGE   = 3'b110
	} msbc_rx_t;
endpackage

// File: logic/msbc_link_if.sv
// single-wire broadcast line between monitor and receiver
`timescale 1ns/1ps
interface msbc_link_if;
	logic serialDataOut;
	modport dev (output serialDataOut);
	modport host (input serialDataOut);
endinterface

// File: logic/msbc_host.sv
// receiver end: decodes the self-clocked broadcast frame
`timescale 1ns/1ps
module msbc_host #(
	parameter int TIMEOUT_CYC = msbc_pkg::TIMEOUT_CYC
) (
	// clock and reset
	input  wire logic  ref_clk,
	input  wire logic  rst_b,
	// broadcast link
	msbc_link_if.host  link,
	// decoded frame
	output logic       frameValid,
	output logic [1:0] frameChannel,
	output logic [9:0] frameResult,
	output logic [2:0] frameFaults,
	output logic       parityOk,
	output logic       frameAbort
);
	msbc_pkg::msbc_rx_t state_r;
	logic        prev_r;
	logic [15:0] cnt_r;
	logic [15:0] half_r;
	logic [15:0] age_r;
	logic [3:0]  bits_r;
	logic [15:0] data_r;
	logic        valid_r;
	logic        abort_r;
	logic [15:0] out_r;
	logic        parity_r;

	wire        line = link.serialDataOut;
	wire        fall = prev_r && !line;
	wire        rise = !prev_r && line;
	wire [15:0] wait34 = half_r + {1'b0, half_r[15:1]};
	wire        late = state_r != msbc_pkg::RX_IDLE
		&& age_r >= 16'(TIMEOUT_CYC);
	wire [15:0] sampled = {data_r[14:0], line};
	// count wraps to zero once all sixteen bits are in
	wire        allIn = bits_r == 4'(msbc_pkg::RX_LAST + 4'h1);

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_r <= msbc_pkg::RX_IDLE;
			prev_r <= 1'b1;
			cnt_r <= 16'h0000;
			half_r <= 16'h0000;
			age_r <= 16'h0000;
			bits_r <= 4'h0;
			data_r <= 16'h0000;
			valid_r <= 1'b0;
			abort_r <= 1'b0;
			out_r <= 16'h0000;
			parity_r <= 1'b0;
		end
		else
		begin
			prev_r <= line;
			cnt_r <= cnt_r + 16'h0001;
			age_r <= state_r == msbc_pkg::RX_IDLE ? 16'h0000 : age_r + 16'h0001;
			valid_r <= 1'b0;
			abort_r <= late;
			if (late)
				state_r <= msbc_pkg::RX_IDLE;
			else
				case (state_r)
					msbc_pkg::RX_IDLE:
						if (fall)
						begin
							cnt_r <= 16'h0000;
							state_r <= msbc_pkg::RX_GLITCH;
						end
					msbc_pkg::RX_GLITCH:
						if (cnt_r == msbc_pkg::GLITCH_CYC - 16'h0001)
							state_r <= line ? msbc_pkg::RX_IDLE : msbc_pkg::RX_START;
					msbc_pkg::RX_START:
						if (rise)
						begin
							cnt_r <= 16'h0001;
							state_r <= msbc_pkg::RX_HALF;
						end
					msbc_pkg::RX_HALF:
						if (fall)
						begin
							half_r <= cnt_r;
							state_r <= msbc_pkg::RX_RISE;
						end
					msbc_pkg::RX_RISE:
						if (rise)
						begin
							cnt_r <= 16'h0001;
							bits_r <= 4'h0;
							state_r <= msbc_pkg::RX_DELAY;
						end
					msbc_pkg::RX_DELAY:
						if (cnt_r >= wait34)
						begin
							data_r <= sampled;
							bits_r <= bits_r + 4'h1;
							state_r <= msbc_pkg::RX_EDGE;
						end
					// close only at the parity mid flip, else its
					// low second half looks like a new start edge
					msbc_pkg::RX_EDGE:
						if ((rise || fall) && allIn)
						begin
							out_r <= data_r;
							parity_r <= ~^data_r;
							valid_r <= 1'b1;
							state_r <= msbc_pkg::RX_IDLE;
						end
						else if (rise || fall)
						begin
							cnt_r <= 16'h0001;
							state_r <= msbc_pkg::RX_DELAY;
						end
					default:
						state_r <= msbc_pkg::RX_IDLE;
				endcase
		end
	end

	assign frameValid = valid_r;
	assign frameChannel = out_r[15:14];
	assign frameResult = out_r[13:4];
	assign frameFaults = out_r[3:1];
	assign parityOk = parity_r;
	assign frameAbort = abort_r;
endmodule

// File: tb/msbc_link_monitor.sv
// checker for the broadcast line and the receiver verdicts
`timescale 1ns/1ps
module msbc_link_monitor (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// link and its surroundings
	input wire logic serialDataOut,
	input wire logic convDone,
	input wire logic broadcastMode,
	input wire logic busEnable,
	input wire logic frameValid,
	input wire logic parityOk,
	input wire logic frameAbort
);
	localparam int HALF = msbc_pkg::HALF_BIT_INT;
	localparam int LAST = 36 * HALF;
	logic [14:0] age_r;
	logic [14:0] age_nxt;
	wire         go;
	wire         midBit;
	wire         inHalf;
	// frame age counted here, not copied from the transmitter
	assign go = convDone && broadcastMode && (age_r == 15'h0);
	assign age_nxt = go ? 15'h1 : (age_r == 15'(LAST)) ? 15'h0
		: (age_r != 15'h0) ? age_r + 15'h1 : 15'h0;
	assign midBit = (age_r != 15'h0) && (age_r % (2 * HALF) == HALF);
	assign inHalf = (age_r != 15'h0) && (age_r % HALF != 0);
	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
			age_r <= 15'h0;
		else
			age_r <= age_nxt;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);
	sequence s_lowRun;
		!serialDataOut [*8];
	endsequence
	sequence s_flip;
		##1 (serialDataOut != $past(serialDataOut));
	endsequence
	property p_mode;
		broadcastMode |-> !busEnable;
	endproperty
	property p_start;
		go |=> s_lowRun;
	endproperty
	property p_split;
		midBit |-> s_flip;
	endproperty
	property p_hold;
		inHalf |=> $stable(serialDataOut);
	endproperty
	property p_dummy;
		(age_r == 15'(2 * HALF + 1)) |-> !serialDataOut;
	endproperty
	property p_idle;
		(age_r == 15'h0) |-> serialDataOut;
	endproperty
	property p_parity;
		frameValid |-> parityOk;
	endproperty
	property p_noAbort;
		(age_r != 15'h0) |-> !frameAbort;
	endproperty
	a_mode: assert property (p_mode)
		else $error("bus left on in broadcast");
	a_start: assert property (p_start)
		else $error("no start low");
	a_split: assert property (p_split)
		else $error("no mid-bit flip");
	a_hold: assert property (p_hold)
		else $error("half bit not held");
	a_dummy: assert property (p_dummy)
		else $error("dummy bit not low");
	a_idle: assert property (p_idle)
		else $error("line not idle high");
	a_parity: assert property (p_parity)
		else $error("parity bad");
	a_noAbort: assert property (p_noAbort)
		else $error("abort in good frame");
endmodule

// File: tb/msbc_tb_top.sv
// bench: both link ends joined, register port and frames checked
`timescale 1ns/1ps
module msbc_tb_top;
	localparam logic [15:0] HI_TAB = 16'h9a10;
	localparam logic [15:0] LO_TAB = 16'h5868;
	localparam logic [31:0] PR_TAB = 32'h30193e2f;
	logic                ref_clk    = 1'b0;
	logic                rst_b      = 1'b0;
	msbc_pkg::msbc_pin_t strapHi    = msbc_pkg::PIN_LOW;
	msbc_pkg::msbc_pin_t strapLo    = msbc_pkg::PIN_LOW;
	logic [7:0]          probe      = 8'h00;
	logic [7:0]          regAddr    = 8'h00;
	logic [7:0]          wrData     = 8'h00;
	logic                regWr      = 1'b0;
	logic                regRd      = 1'b0;
	logic                convDone   = 1'b0;
	logic [9:0]          convResult = 10'h000;
	logic [8:0]          cond       = 9'h000;
	logic                pgCheckEnd = 1'b0;
	logic [2:0]          ev         = 3'h0;
	logic [1:0]          ch         = 2'h0;
	logic [1:0]          c;
	logic [7:0]          rdData;
	logic [7:0]          busAddr;
	logic                broadcastMode;
	logic                busEnable;
	logic                addrHit;
	logic                frameValid;
	logic [1:0]          frameChannel;
	logic [9:0]          frameResult;
	logic [2:0]          frameFaults;
	logic                parityOk;
	logic                frameAbort;
	int                  fails      = 0;
	int                  nChecks    = 0;
	int                  cyc        = 0;
	msbc_link_if link ();
	msbc_device msbc_device_inst (.ref_clk(ref_clk), .rst_b(rst_b),
		.link(link), .addrSelectHi(strapHi), .addrSelectLo(strapLo),
		.addrProbe(probe), .regAddr(regAddr), .regWrData(wrData),
		.regWr(regWr), .regRd(regRd), .regRdData(rdData),
		.convBusy(1'b0), .convDone(convDone), .convResult(convResult),
		.switchOn(cond[8]), .pgioLevel(cond[7]), .senseShort(cond[6]),
		.boardDetect(cond[5]), .overcurrentNow(cond[4]),
		.undervoltUpper(cond[3]), .undervoltLower(cond[2]),
		.highLineComparator(cond[1]), .supplyGood(cond[0]),
		.pgCheckEnd(pgCheckEnd), .ocEvent(ev[2]), .uvEvent(ev[1]),
		.ovEvent(ev[0]), .broadcastMode(broadcastMode),
		.busEnable(busEnable), .busAddr(busAddr), .addrHit(addrHit),
		.alertEnables(), .control());
	msbc_host msbc_host_inst (.ref_clk(ref_clk), .rst_b(rst_b),
		.link(link), .frameValid(frameValid),
		.frameChannel(frameChannel), .frameResult(frameResult),
		.frameFaults(frameFaults), .parityOk(parityOk),
		.frameAbort(frameAbort));
	msbc_link_monitor msbc_link_monitor_inst (.ref_clk(ref_clk),
		.rst_b(rst_b), .serialDataOut(link.serialDataOut),
		.convDone(convDone), .broadcastMode(broadcastMode),
		.busEnable(busEnable), .frameValid(frameValid),
		.parityOk(parityOk), .frameAbort(frameAbort));
	always #25 ref_clk = ~ref_clk;
	task automatic test_done;
		if (fails == 0 && nChecks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
		nChecks++;
		if (exp !== got)
		begin
			fails++;
			$display("[ERR] %s exp %h got %h", name, exp, got);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		wrData <= d;
		regWr <= 1'b1;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe is taken
	task automatic rd(logic [7:0] a, logic [7:0] exp);
		@(posedge ref_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge ref_clk);
		regRd <= 1'b0;
		@(posedge ref_clk);
		chk("regRdData", 16'(exp), 16'(rdData));
	endtask
	task automatic conv(logic [9:0] r);
		@(posedge ref_clk);
		convResult <= r;
		convDone <= 1'b1;
		@(posedge ref_clk);
		convDone <= 1'b0;
		ch = (ch == 2'h2) ? 2'h0 : ch + 2'h1;
	endtask
	task automatic evt(logic [2:0] e);
		@(posedge ref_clk);
		ev <= e;
		@(posedge ref_clk);
		ev <= 3'h0;
	endtask
	task automatic frame(logic [1:0] fc, logic [9:0] r, logic [2:0] f);
		int i;
		for (i = 0; i < 30000 && frameValid !== 1'b1; i++)
			@(posedge ref_clk);
		chk("frameValid", 16'h1, 16'(frameValid));
		chk("frameChannel", 16'(fc), 16'(frameChannel));
		chk("frameResult", 16'(r), 16'(frameResult));
		chk("frameFaults", 16'(f), 16'(frameFaults));
		chk("parityOk", 16'h1, 16'(parityOk));
		// let the parity bit finish before the next conversion
		repeat (1400) @(posedge ref_clk);
	endtask
	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 70000)
		begin
			fails++;
			test_done();
		end
	end
	initial
	begin
		repeat (4) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		for (int i = 0; i < 8; i++)
		begin
			strapHi <= msbc_pkg::msbc_pin_t'(HI_TAB[2*i+:2]);
			strapLo <= msbc_pkg::msbc_pin_t'(LO_TAB[2*i+:2]);
			repeat (3) @(posedge ref_clk);
			chk("busAddr", 16'(8'h20 + 8'(2 * i)), 16'(busAddr));
			chk("busEnable", 16'h1, 16'(busEnable));
		end
		for (int i = 0; i < 4; i++)
		begin
			probe <= PR_TAB[8*i+:8];
			repeat (2) @(posedge ref_clk);
			chk("addrHit", 16'(i != 3), 16'(addrHit));
		end
		cond <= 9'h1e2;
		rd(8'h00, 8'h93);
		wr(8'h03, 8'hc0);
		rd(8'h00, 8'hd3);
		rd(8'h03, 8'hc0);
		@(posedge ref_clk);
		cond <= 9'h059;
		pgCheckEnd <= 1'b1;
		@(posedge ref_clk);
		pgCheckEnd <= 1'b0;
		wr(8'h00, 8'hff);
		rd(8'h00, 8'h2c);
		conv(10'h2b7);
		rd(8'hf4, 8'had);
		rd(8'h05, 8'h03);
		wr(8'h04, 8'h55);
		rd(8'h04, 8'had);
		wr(8'h03, 8'h20);
		wr(8'h04, 8'h55);
		rd(8'h04, 8'h55);
		wr(8'h0c, 8'hff);
		rd(8'h0c, 8'h00);
		wr(8'h03, 8'h00);
		evt(3'h4);
		rd(8'h01, 8'h04);
		evt(3'h3);
		rd(8'h01, 8'h07);
		wr(8'h01, 8'h00);
		rd(8'h01, 8'h00);
		evt(3'h4);
		@(posedge ref_clk);
		strapHi <= msbc_pkg::PIN_HIGH;
		strapLo <= msbc_pkg::PIN_LOW;
		probe <= 8'h3e;
		repeat (3) @(posedge ref_clk);
		chk("broadcastMode", 16'h1, 16'(broadcastMode));
		chk("busEnable", 16'h0, 16'(busEnable));
		chk("addrHit", 16'h0, 16'(addrHit));
		c = ch;
		// odd payload: parity one, so the line falls mid parity bit
		conv(10'h3c4);
		repeat (100) @(posedge ref_clk);
		// this one lands mid-frame: dropped, channel still advances
		conv(10'h155);
		frame(c, 10'h3c4, 3'h4);
		evt(3'h2);
		c = ch;
		conv(10'h0a6);
		frame(c, 10'h0a6, 3'h6);
		test_done();
	end
endmodule
